/* File: mtc_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mtc_bus_model (
  input wire logic pclk,
  output var logic [1:0] rx_pos,
  output var logic [1:0] rx_neg
);
  // Quiet bus: no receiver activity on either channel
  initial begin
    rx_pos = 2'b00;
    rx_neg = 2'b00;
  end
  // One word on channel 0, MSB first, odd parity
  task automatic send(input logic cmd, input logic [15:0] w);
    logic [39:0] h;
    logic b;
    h[39:34] = cmd ? 6'b111000 : 6'b000111;
    for (int i = 0; i < 17; i++) begin
      b = (i < 16) ? w[15 - i] : ~^w;
      h[33 - 2 * i -: 2] = b ? 2'b10 : 2'b01;
    end
    for (int i = 39; i >= 0; i--) begin
      rx_pos[0] <= h[i];
      rx_neg[0] <= ~h[i];
      repeat (mtc_pkg::HALF_BIT_CYC) @(posedge pclk);
    end
    rx_pos[0] <= 1'b0;
    rx_neg[0] <= 1'b0;
    // One quiet cycle so a following word never reassigns in the same step
    @(posedge pclk);
  endtask : send
endmodule : mtc_bus_model
`default_nettype wire

/* File: mtc_core.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mtc_core #(
  parameter bit BC_PRESENT = 1'b1,
  parameter bit DUAL_XCVR = 1'b1,
  parameter int unsigned TMO_CYC = mtc_pkg::TMO_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] rt_address,
  input wire logic rt_address_parity,
  input wire logic transceiver_type_select,
  input wire logic [1:0] rx_pos,
  input wire logic [1:0] rx_neg,
  output logic [1:0] tx_pos,
  output logic [1:0] tx_neg,
  output logic [1:0] tx_inhibit,
  output logic [3:0] disc_ctl
);

  mtc_pkg::mtc_word_t dec_w [2];
  mtc_pkg::mtc_word_t w;
  mtc_pkg::mtc_rt_t rt_st;
  mtc_pkg::mtc_fr_t fr_st;
  mtc_pkg::mtc_cm_t cm_st;
  logic [1:0] dec_perr;
  logic [1:0] tx_active;
  logic wch;
  logic enc_busy;
  logic enc_load;
  logic enc_chan;
  logic enc_cs;
  logic [15:0] enc_data;
  logic [15:0] mem [mtc_pkg::MEM_DEPTH];
  logic [15:0] regs [32];
  logic [15:0] cfg;
  logic [31:0] msel;
  logic acc, is_mem, bad, we_lo, we_hi, start, bc_mode, std_on;
  logic [10:0] pair;
  logic [4:0] wi_lo, wi_hi;
  logic [3:0] err, err_set, err_clr;
  logic [15:0] rt_cmd, cm_cmd, msg_left;
  logic [5:0] rt_idx, cm_idx, rt_n, cm_n;
  logic rt_chan, rt_go, mine, bcast, rt_busy, rt_wr;
  logic [11:0] msg_ptr, core_a, mon_a;
  logic cm_go, cm_done, cm_wr, cm_bc, core_we, mon_we, mon_on;
  logic [9:0] mptr;
  logic [13:0] wcnt;
  logic waiting, tmo;

  // Payload length of a command; mode codes carry at most one word
  function automatic logic [5:0] mtc_len(input logic [15:0] c);
    if (c[9:5] == 5'h00 || c[9:5] == 5'h1F) begin
      return {5'h00, c[4]};
    end
    return (c[4:0] == 5'h00) ? 6'h20 : {1'b0, c[4:0]};
  endfunction : mtc_len

  // Half-bit pattern: sync, Manchester data, odd parity
  function automatic logic [39:0] mtc_encode(input logic [15:0] d, input logic cs);
    logic [39:0] r;
    r = '0;
    r[39:34] = cs ? 6'h38 : 6'h07;
    for (int i = 0; i < 16; i++) begin
      r[33 - 2 * i -: 2] = {d[15 - i], ~d[15 - i]};
    end
    r[1:0] = {~^d, ^d};
    return r;
  endfunction : mtc_encode

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [6:0] dcnt, ecnt;
    logic [39:0] dsh, esh;
    logic [15:0] dd;
    logic [5:0] eleft;
    logic dprev, dok, line, tx_p, tx_n;
    assign line = rx_pos[ch] & ~rx_neg[ch];
    // Sync and Manchester pair check over the half-bit history
    always_comb begin
      dok = (dsh[39:34] == 6'h38) || (dsh[39:34] == 6'h07);
      dd = '0;
      for (int k = 0; k < 17; k++) begin
        if (dsh[2 * k + 1] == dsh[2 * k]) begin
          dok = 1'b0;
        end
      end
      for (int k = 0; k < 16; k++) begin
        dd[k] = dsh[2 * k + 3];
      end
    end
    assign dec_w[ch] = {dok & (^{dd, dsh[1]}), dsh[39], dd};
    assign dec_perr[ch] = dok & ~(^{dd, dsh[1]});
    // Sampler recentres on every line edge to ride out clock skew
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dprev <= 1'b0;
        dcnt <= 7'h00;
        dsh <= '0;
      end else begin
        dprev <= line;
        if (line != dprev) begin
          dcnt <= mtc_pkg::HALF_CENTER;
        end else if (dcnt == 7'h00) begin
          dcnt <= mtc_pkg::HALF_BIT_CYC - 7'h01;
        end else begin
          dcnt <= dcnt - 7'h01;
        end
        // Own echo is discarded so it never looks like a reply
        if (dok || tx_active[ch]) begin
          dsh <= '0;
        end else if (dcnt == 7'h00 && line == dprev) begin
          dsh <= {dsh[38:0], line};
        end
      end
    end
    // Encoder shifts one half-bit per divider pulse
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        esh <= '0;
        eleft <= 6'h00;
        ecnt <= 7'h00;
        tx_p <= 1'b0;
        tx_n <= 1'b0;
      end else begin
        tx_p <= (eleft != 6'h00) & esh[39];
        tx_n <= (eleft != 6'h00) & ~esh[39];
        if (enc_load && enc_chan == ch && eleft == 6'h00) begin
          esh <= mtc_encode(enc_data, enc_cs);
          eleft <= mtc_pkg::ENC_HALVES;
          ecnt <= mtc_pkg::HALF_BIT_CYC - 7'h01;
        end else if (eleft != 6'h00) begin
          if (ecnt == 7'h00) begin
            esh <= {esh[38:0], 1'b0};
            eleft <= eleft - 6'h01;
            ecnt <= mtc_pkg::HALF_BIT_CYC - 7'h01;
          end else begin
            ecnt <= ecnt - 7'h01;
          end
        end
      end
    end
    assign tx_active[ch] = eleft != 6'h00;
    // Transceiver type steering
    assign tx_pos[ch] = std_on & tx_p;
    assign tx_neg[ch] = std_on & tx_n;
    assign tx_inhibit[ch] = ~(std_on & tx_active[ch]);
    assign disc_ctl[2 * ch + 1 -: 2] = std_on ? 2'b00 : {tx_active[ch], tx_p};
  end

  assign std_on = !DUAL_XCVR || transceiver_type_select;
  assign enc_busy = |tx_active;
  assign w = dec_w[0].valid ? dec_w[0] : dec_w[1];
  assign wch = !dec_w[0].valid;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Zero wait states: read data is captured in the setup cycle
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign is_mem = paddr[mtc_pkg::MEM_SEL_BIT];
  assign pair = paddr[12:2];
  assign bad = is_mem ? (paddr[16:13] != 4'h0) : (paddr[16:6] != 11'h000);
  assign pslverr = acc & bad;
  assign we_lo = acc & pwrite & ~bad & (|pstrb[1:0]);
  assign we_hi = acc & pwrite & ~bad & (|pstrb[3:2]);
  assign wi_lo = {paddr[5:2], 1'b0};
  assign wi_hi = {paddr[5:2], 1'b1};
  assign cfg = regs[mtc_pkg::REG_CFG];
  assign msel = {regs[mtc_pkg::REG_MSEL_HI], regs[mtc_pkg::REG_MSEL_LO]};
  assign bc_mode = BC_PRESENT && cfg[mtc_pkg::CFG_BC_MODE];
  assign start = ~is_mem & ((we_lo & wi_lo == mtc_pkg::REG_CMD & pwdata[mtc_pkg::CMD_START])
                 | (we_hi & wi_hi == mtc_pkg::REG_CMD & pwdata[16 + mtc_pkg::CMD_START]));
  assign err_clr = ((we_lo & ~is_mem & wi_lo == mtc_pkg::REG_ERR) ? pwdata[3:0] : 4'h0)
                 | ((we_hi & ~is_mem & wi_hi == mtc_pkg::REG_ERR) ? pwdata[19:16] : 4'h0);

  // Register read view; live state sits beside stored settings
  function automatic logic [15:0] reg_rd(input logic [4:0] i);
    case (i)
      mtc_pkg::REG_CMD: return 16'h0000;
      mtc_pkg::REG_STAT: return {4'h0, cm_st, fr_st, rt_st};
      mtc_pkg::REG_MPTR: return {6'h00, mptr};
      mtc_pkg::REG_LAST_CMD: return rt_cmd;
      mtc_pkg::REG_ERR: return {12'h000, err};
      default: return regs[i];
    endcase
  endfunction : reg_rd

  // Read capture, both halves in one transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (is_mem) begin
        prdata <= {mem[{pair, 1'b1}], mem[{pair, 1'b0}]};
      end else begin
        prdata <= {reg_rd(wi_hi), reg_rd(wi_lo)};
      end
    end
  end

  // Stored registers; live ones ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 16'h0000;
      end
      regs[mtc_pkg::REG_CFG] <= mtc_pkg::CFG_RST;
    end else if (!is_mem) begin
      if (we_lo && wi_lo != mtc_pkg::REG_STAT && wi_lo != mtc_pkg::REG_LAST_CMD) begin
        regs[wi_lo] <= pwdata[15:0];
      end
      if (we_hi && wi_hi != mtc_pkg::REG_CMD && wi_hi != mtc_pkg::REG_ERR
          && wi_hi != mtc_pkg::REG_MPTR) begin
        regs[wi_hi] <= pwdata[31:16];
      end
    end
  end

  // Sticky errors, a new event beats a clear in the same cycle
  assign err_set = {1'b0, (rt_st == mtc_pkg::RT_RX && w.valid && w.cmd_sync)
                    | (cm_st == mtc_pkg::CM_STAT && w.valid && !w.cmd_sync),
                    tmo, |dec_perr};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 4'h0;
    end else begin
      err <= (err & ~err_clr) | err_set;
    end
  end

  // Message memory; host write lands last so it wins a collision
  always_ff @(posedge pclk) begin
    if (core_we) begin
      mem[core_a] <= w.data;
    end
    if (mon_we) begin
      mem[mon_a] <= w.data;
    end
    if (we_lo && is_mem) begin
      mem[{pair, 1'b0}] <= pwdata[15:0];
    end
    if (we_hi && is_mem) begin
      mem[{pair, 1'b1}] <= pwdata[31:16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote terminal

  assign bcast = w.data[15:11] == 5'h1F;
  // Bad strap parity leaves only broadcast reachable
  assign mine = bcast || (w.data[15:11] == rt_address && ^{rt_address, rt_address_parity});
  assign rt_go = w.valid & w.cmd_sync & cfg[mtc_pkg::CFG_RT_EN] & ~bc_mode & mine;
  assign rt_busy = cfg[mtc_pkg::CFG_BUSY] | ~cfg[mtc_pkg::CFG_READY];
  assign rt_n = mtc_len(rt_cmd);
  assign rt_wr = rt_st == mtc_pkg::RT_RX && w.valid && !w.cmd_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_st <= mtc_pkg::RT_IDLE;
      rt_cmd <= 16'h0000;
      rt_idx <= 6'h00;
      rt_chan <= 1'b0;
    end else begin
      case (rt_st)
        mtc_pkg::RT_IDLE: begin
          rt_idx <= 6'h00;
          if (rt_go) begin
            rt_cmd <= w.data;
            rt_chan <= wch;
            if (!w.data[10] && mtc_len(w.data) != 6'h00) begin
              rt_st <= mtc_pkg::RT_RX;
            end else if (!bcast) begin
              rt_st <= mtc_pkg::RT_STAT;
            end
          end
        end
        mtc_pkg::RT_RX: begin
          if (tmo || (w.valid && w.cmd_sync)) begin
            rt_st <= mtc_pkg::RT_IDLE;
          end else if (w.valid) begin
            rt_idx <= rt_idx + 6'h01;
            if (rt_idx == rt_n - 6'h01) begin
              rt_st <= (rt_cmd[15:11] == 5'h1F) ? mtc_pkg::RT_IDLE : mtc_pkg::RT_STAT;
            end
          end
        end
        mtc_pkg::RT_STAT: begin
          rt_idx <= 6'h00;
          if (!enc_busy) begin
            rt_st <= (rt_cmd[10] && rt_n != 6'h00 && !rt_busy) ? mtc_pkg::RT_TX
                     : mtc_pkg::RT_IDLE;
          end
        end
        mtc_pkg::RT_TX: begin
          if (!enc_busy) begin
            rt_idx <= rt_idx + 6'h01;
            if (rt_idx == rt_n - 6'h01) begin
              rt_st <= mtc_pkg::RT_IDLE;
            end
          end
        end
        default: rt_st <= mtc_pkg::RT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor

  assign mon_we = w.valid & cfg[mtc_pkg::CFG_MT_EN] & (w.cmd_sync ? msel[w.data[15:11]] : mon_on);
  assign mon_a = mtc_pkg::MEM_MON_BASE + {2'b00, mptr};
  // Pointer wraps inside its 1K window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_on <= 1'b0;
      mptr <= 10'h000;
    end else begin
      if (w.valid && w.cmd_sync && cfg[mtc_pkg::CFG_MT_EN]) begin
        mon_on <= msel[w.data[15:11]];
      end
      if (mon_we) begin
        mptr <= mptr + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame and command machines

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_st <= mtc_pkg::FR_IDLE;
      msg_ptr <= 12'h000;
      msg_left <= 16'h0000;
      cm_go <= 1'b0;
    end else begin
      cm_go <= 1'b0;
      case (fr_st)
        mtc_pkg::FR_IDLE: begin
          if (start && bc_mode && cm_st == mtc_pkg::CM_IDLE && rt_st == mtc_pkg::RT_IDLE) begin
            fr_st <= mtc_pkg::FR_LOAD;
          end
        end
        mtc_pkg::FR_LOAD: begin
          msg_ptr <= mem[mtc_pkg::MEM_FRAME_PTR][11:0];
          msg_left <= mem[mtc_pkg::MEM_FRAME_CNT];
          cm_go <= mem[mtc_pkg::MEM_FRAME_CNT] != 16'h0000;
          fr_st <= (mem[mtc_pkg::MEM_FRAME_CNT] != 16'h0000) ? mtc_pkg::FR_RUN : mtc_pkg::FR_IDLE;
        end
        mtc_pkg::FR_RUN: begin
          if (cm_done) begin
            if (msg_left == 16'h0001) begin
              fr_st <= mtc_pkg::FR_IDLE;
            end else begin
              msg_left <= msg_left - 16'h0001;
              msg_ptr <= msg_ptr + mtc_pkg::DESC_WORDS;
              cm_go <= 1'b1;
            end
          end
        end
        default: fr_st <= mtc_pkg::FR_IDLE;
      endcase
    end
  end

  assign cm_n = mtc_len(cm_cmd);
  assign cm_bc = cm_cmd[15:11] == 5'h1F;
  assign cm_wr = w.valid && ((cm_st == mtc_pkg::CM_STAT && w.cmd_sync)
                 || (cm_st == mtc_pkg::CM_RXD && !w.cmd_sync));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_st <= mtc_pkg::CM_IDLE;
      cm_cmd <= 16'h0000;
      cm_idx <= 6'h00;
      cm_done <= 1'b0;
    end else begin
      cm_done <= 1'b0;
      case (cm_st)
        mtc_pkg::CM_IDLE: begin
          cm_idx <= 6'h00;
          if (cm_go) begin
            cm_cmd <= mem[msg_ptr];
            cm_st <= mtc_pkg::CM_CMD;
          end
        end
        mtc_pkg::CM_CMD: begin
          if (!enc_busy) begin
            if (!cm_cmd[10] && cm_n != 6'h00) begin
              cm_st <= mtc_pkg::CM_DATA;
            end else if (cm_bc) begin
              cm_st <= mtc_pkg::CM_IDLE;
              cm_done <= 1'b1;
            end else begin
              cm_st <= mtc_pkg::CM_STAT;
            end
          end
        end
        mtc_pkg::CM_DATA: begin
          if (!enc_busy) begin
            cm_idx <= cm_idx + 6'h01;
            if (cm_idx == cm_n - 6'h01) begin
              cm_st <= cm_bc ? mtc_pkg::CM_IDLE : mtc_pkg::CM_STAT;
              cm_done <= cm_bc;
            end
          end
        end
        mtc_pkg::CM_STAT: begin
          cm_idx <= 6'h00;
          if (w.valid && w.cmd_sync && cm_cmd[10] && cm_n != 6'h00) begin
            cm_st <= mtc_pkg::CM_RXD;
          end else if (w.valid || tmo) begin
            cm_st <= mtc_pkg::CM_IDLE;
            cm_done <= 1'b1;
          end
        end
        mtc_pkg::CM_RXD: begin
          if (w.valid && !w.cmd_sync) begin
            cm_idx <= cm_idx + 6'h01;
          end
          if (tmo || (w.valid && (w.cmd_sync || cm_idx == cm_n - 6'h01))) begin
            cm_st <= mtc_pkg::CM_IDLE;
            cm_done <= 1'b1;
          end
        end
        default: cm_st <= mtc_pkg::CM_IDLE;
      endcase
    end
  end

  // Shared word-gap timer; only one side runs at a time
  assign waiting = !enc_busy && (rt_st == mtc_pkg::RT_RX || cm_st == mtc_pkg::CM_STAT
                   || cm_st == mtc_pkg::CM_RXD);
  assign tmo = waiting && wcnt == 14'(TMO_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 14'h0000;
    end else if (!waiting || w.valid || tmo) begin
      wcnt <= 14'h0000;
    end else begin
      wcnt <= wcnt + 14'h0001;
    end
  end

  // Core write port and encoder source
  assign core_we = rt_wr | cm_wr;
  assign core_a = rt_wr ? mtc_pkg::MEM_RT_RX_BASE + {2'b00, rt_cmd[9:5], rt_idx[4:0]}
                  : msg_ptr + ((cm_st == mtc_pkg::CM_STAT) ? 12'h001 : 12'h002 + {6'h00, cm_idx});
  always_comb begin
    enc_load = 1'b0;
    enc_cs = 1'b0;
    enc_chan = rt_chan;
    enc_data = 16'h0000;
    if (rt_st == mtc_pkg::RT_STAT) begin
      enc_load = !enc_busy;
      enc_cs = 1'b1;
      enc_data = {rt_address, 7'h00, rt_busy, 3'h0};
    end else if (rt_st == mtc_pkg::RT_TX) begin
      enc_load = !enc_busy;
      enc_data = mem[mtc_pkg::MEM_RT_TX_BASE + {2'b00, rt_cmd[9:5], rt_idx[4:0]}];
    end else if (cm_st == mtc_pkg::CM_CMD || cm_st == mtc_pkg::CM_DATA) begin
      enc_load = !enc_busy;
      enc_chan = cfg[mtc_pkg::CFG_BC_CHAN];
      enc_cs = cm_st == mtc_pkg::CM_CMD;
      enc_data = enc_cs ? cm_cmd : mem[msg_ptr + 12'h002 + {6'h00, cm_idx}];
    end
  end

endmodule : mtc_core
`default_nettype wire

/* File: mtc_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("Error %0t: got %h want %h", $time, a, e); end end
module mtc_core_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [4:0] rt_address = 5'h00;
  logic transceiver_type_select = 1'b1;
  logic [31:0] prdata, d, a, e_n, m_n;
  logic pready, pslverr;
  logic [1:0] rx_pos, rx_neg, tx_pos, tx_neg, tx_inhibit;
  logic [3:0] disc_ctl;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int failures = 0;
  int comparisons = 0;
  int seed = 50;
  // 250 MHz
  always #2 pclk = ~pclk;
  mtc_core #(.TMO_CYC(6000)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rt_address(rt_address),
    .rt_address_parity(~^rt_address), .transceiver_type_select(transceiver_type_select),
    .rx_pos(rx_pos), .rx_neg(rx_neg), .tx_pos(tx_pos), .tx_neg(tx_neg),
    .tx_inhibit(tx_inhibit), .disc_ctl(disc_ctl));
  mtc_bus_model bus (.pclk(pclk), .rx_pos(rx_pos), .rx_neg(rx_neg));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // One APB transfer with an idle cycle first; reads leave a note
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd,
      input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= s;
    if (!w) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask : xfer
  // Bounded wait for channel 0 inhibit to reach v
  task automatic wait_inh(input logic v);
    int n;
    n = 0;
    while (tx_inhibit[0] !== v && n < 15000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(tx_inhibit[0], v)
    if (n >= 15000) summarize();
  endtask : wait_inh
  // Oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      e_n = exp_q.pop_front();
      m_n = msk_q.pop_front();
      `CHK(prdata & m_n, e_n)
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    // Address kept off the broadcast value so the terminal answers
    rt_address <= {1'b0, 4'($random(seed))};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then a start without controller mode is ignored
    xfer(0, 32'h0, 0, 0, 32'h0000_0003, '1);
    xfer(0, 32'h4, 0, 0, 32'h0000_0091, 32'h0000_FFFF);
    xfer(1, 32'h0, 32'h0001_0000, 4'hC, 0, 0);
    xfer(0, 32'h4, 0, 0, 32'h0000_0091, 32'h0000_FFFF);
    // Plain storage: full write, then the even half alone
    for (int i = 4; i < 16; i++) begin
      d = $random(seed);
      xfer(1, 32'(i * 4), d, 4'hF, 0, 0);
      xfer(1, 32'(i * 4), ~d, 4'h3, 0, 0);
      xfer(0, 32'(i * 4), 0, 0, {d[31:16], ~d[15:0]}, '1);
    end
    // Refused register write must not alias onto the last pair written
    xfer(1, 32'h7C, ~d, 4'hF, 0, 0);
    xfer(0, 32'h3C, 0, 0, {d[31:16], ~d[15:0]}, '1);
    // Memory ends, word LSB ignored, out-of-range write dropped
    for (int k = 0; k < 2; k++) begin
      a = k ? 32'h0002_1FFC : 32'h0002_0010;
      d = $random(seed);
      xfer(1, a, d, 4'hF, 0, 0);
      xfer(0, a | 32'h2, 0, 0, d, '1);
    end
    xfer(1, 32'h0002_0000, d, 4'hF, 0, 0);
    xfer(1, 32'h0002_2000, ~d, 4'hF, 0, 0);
    xfer(0, 32'h0002_0000, 0, 0, d, '1);
    // Transmit command before the host is ready: busy status answer
    bus.send(1'b1, {rt_address, 1'b1, 5'h01, 5'h01});
    wait_inh(1'b0);
    wait_inh(1'b1);
    xfer(0, 32'hC, 0, 0, {16'h0, rt_address, 11'h421}, 32'h0000_FFFF);
    xfer(0, 32'hC, 0, 0, 32'h0, 32'hFFFF_0000);
    // Receive message after ready: data word lands in memory
    xfer(1, 32'h0, 32'h0000_0023, 4'h3, 0, 0);
    d = $random(seed);
    bus.send(1'b1, {rt_address, 1'b0, 5'h02, 5'h01});
    bus.send(1'b0, d[15:0]);
    wait_inh(1'b0);
    xfer(0, 32'h0002_0880, 0, 0, {16'h0, d[15:0]}, 32'h0000_FFFF);
    wait_inh(1'b1);
    // One-message broadcast frame: command, one-cycle gap, data, then idle
    xfer(1, 32'h0002_0200, 32'h0001_0200, 4'hF, 0, 0);
    xfer(1, 32'h0002_0400, 32'h0000_F861, 4'hF, 0, 0);
    xfer(1, 32'h0002_0404, d, 4'hF, 0, 0);
    xfer(1, 32'h0, 32'h0000_0024, 4'h3, 0, 0);
    xfer(1, 32'h0, 32'h0001_0000, 4'hC, 0, 0);
    wait_inh(1'b0);
    wait_inh(1'b1);
    wait_inh(1'b0);
    wait_inh(1'b1);
    xfer(0, 32'h4, 0, 0, 32'h0000_0091, 32'h0000_FFFF);
    // Discrete transceiver selected: standard lines stay quiet
    transceiver_type_select <= 1'b0;
    repeat (20) @(posedge pclk);
    summarize();
  end
endmodule : mtc_core_bench
`default_nettype wire

/* File: mtc_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mtc_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transceiver_type_select,
  input wire logic [1:0] tx_pos,
  input wire logic [1:0] tx_neg,
  input wire logic [1:0] tx_inhibit,
  input wire logic [3:0] disc_ctl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  wire logic acc = psel && penable;
  ////////////////////////////////////////////////////////////////
  // Host bus
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_reg_ok; acc && !paddr[17] && paddr[16:6] == 11'h0 |-> !pslverr; endproperty
  a_reg_ok: assert property (p_reg_ok) else $error("register refused");
  property p_reg_bad; acc && !paddr[17] && paddr[16:6] != 11'h0 |-> pslverr; endproperty
  a_reg_bad: assert property (p_reg_bad) else $error("bad register taken");
  property p_mem; acc && paddr[17] |-> pslverr == (paddr[16:13] != 4'h0); endproperty
  a_mem: assert property (p_mem) else $error("memory range decode");
  // Read data only moves after a read setup cycle
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  ////////////////////////////////////////////////////////////////
  // Transceiver lines
  property p_std; transceiver_type_select |-> disc_ctl == 4'h0; endproperty
  a_std: assert property (p_std) else $error("discrete lines active");
  property p_disc; !transceiver_type_select |-> tx_pos == 2'b00 && tx_neg == 2'b00; endproperty
  a_disc: assert property (p_disc) else $error("standard lines active");
  property p_excl; (tx_pos & tx_neg) == 2'b00; endproperty
  a_excl: assert property (p_excl) else $error("both drive phases high");
  property p_rst; $rose(presetn) |-> tx_inhibit == 2'b11 && disc_ctl == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
endmodule : mtc_core_props
bind mtc_core mtc_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .transceiver_type_select(transceiver_type_select), .tx_pos(tx_pos),
  .tx_neg(tx_neg), .tx_inhibit(tx_inhibit), .disc_ctl(disc_ctl));
`default_nettype wire

/* File: mtc_pkg.sv */
`default_nettype none
package mtc_pkg;
  // Clock and bus timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned HALF_BIT_NS = 500;
  localparam logic [6:0] HALF_BIT_CYC = 7'(HALF_BIT_NS * CLK_MHZ / 1000);
  localparam logic [6:0] HALF_CENTER = 7'(HALF_BIT_NS * CLK_MHZ / 2000);
  localparam logic [5:0] ENC_HALVES = 6'h28;
  // Gap allowed between two words seen by a waiting machine
  localparam int unsigned TMO_US = 34;
  localparam int unsigned TMO_CYC_DEF = TMO_US * CLK_MHZ;
  // Message memory
  localparam int unsigned MEM_DEPTH = 4096;
  localparam logic [11:0] MEM_FRAME_PTR = 12'h0100;
  localparam logic [11:0] MEM_FRAME_CNT = 12'h0101;
  localparam logic [11:0] MEM_RT_RX_BASE = 12'h0400;
  localparam logic [11:0] MEM_RT_TX_BASE = 12'h0800;
  localparam logic [11:0] MEM_MON_BASE = 12'h0C00;
  localparam logic [11:0] DESC_WORDS = 12'h022;
  // APB address layout
  localparam int unsigned MEM_SEL_BIT = 17;
  // Register indices
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_CMD = 5'h01;
  localparam logic [4:0] REG_STAT = 5'h02;
  localparam logic [4:0] REG_MSEL_LO = 5'h03;
  localparam logic [4:0] REG_MSEL_HI = 5'h04;
  localparam logic [4:0] REG_MPTR = 5'h05;
  localparam logic [4:0] REG_LAST_CMD = 5'h06;
  localparam logic [4:0] REG_ERR = 5'h07;
  // Config fields and reset value
  localparam int unsigned CFG_RT_EN = 0;
  localparam int unsigned CFG_MT_EN = 1;
  localparam int unsigned CFG_BC_MODE = 2;
  localparam int unsigned CFG_BUSY = 3;
  localparam int unsigned CFG_BC_CHAN = 4;
  localparam int unsigned CFG_READY = 5;
  localparam logic [15:0] CFG_RST = 16'h0003;
  localparam int unsigned CMD_START = 0;
  // Error flags
  localparam int unsigned ERR_PARITY = 0;
  localparam int unsigned ERR_TIMEOUT = 1;
  localparam int unsigned ERR_SEQ = 2;
  // Decoded word with its status
  typedef struct packed {
    logic valid;
    logic cmd_sync;
    logic [15:0] data;
  } mtc_word_t;
  typedef enum logic [3:0] {
    RT_IDLE = 4'h1, RT_RX = 4'h2, RT_STAT = 4'h4, RT_TX = 4'h8
  } mtc_rt_t;
  typedef enum logic [2:0] {FR_IDLE = 3'h1, FR_LOAD = 3'h2, FR_RUN = 3'h4} mtc_fr_t;
  typedef enum logic [4:0] {
    CM_IDLE = 5'h01, CM_CMD = 5'h02, CM_DATA = 5'h04, CM_STAT = 5'h08, CM_RXD = 5'h10
  } mtc_cm_t;
endpackage : mtc_pkg
`default_nettype wire
